// >>> src/gpa_pkg.sv
// Purpose: Shared constants and types for the 8-bit port with analog share.
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register.
// Notes:   Oscillator mode codes are held in a software register of the block.
package gpa_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] GPA_OFS_PIN_LEVEL = 5'h00;
  localparam logic [4:0] GPA_OFS_OUT_LATCH = 5'h04;
  localparam logic [4:0] GPA_OFS_DIRECTION = 5'h08;
  localparam logic [4:0] GPA_OFS_CONV_CFG = 5'h0C;
  localparam logic [4:0] GPA_OFS_OSC_CFG = 5'h10;

  // ----------------------------------------------------------------
  // Widths, fields and reset values
  // ----------------------------------------------------------------
  localparam int GPA_W = 8;
  localparam logic [7:0] GPA_RST_LATCH = 8'h00;
  localparam logic [7:0] GPA_RST_DIR = 8'hFF;
  localparam logic [3:0] GPA_RST_ASEL = 4'h0;
  localparam logic [1:0] GPA_RST_RSEL = 2'h0;
  localparam int GPA_ASEL_LSB = 0;
  localparam int GPA_RSEL_LSB = 4;
  localparam int GPA_OSC_LSB = 0;
  // Analog select code above which a channel turns digital
  localparam logic [3:0] GPA_ASEL_TOP = 4'hE;
  // Pin positions with special duties
  localparam int GPA_BIT_TMR = 4;
  localparam int GPA_BIT_CYC_OUT = 6;
  localparam int GPA_BIT_MAIN_IN = 7;
  // Pins that carry an analog channel: 0..3 are channels 0..3, pin 5 is channel 4
  localparam logic [7:0] GPA_ANALOG_PINS = 8'h2F;
  localparam logic [3:0] GPA_PIN5_CHAN = 4'h4;
  localparam logic [31:0] GPA_RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Oscillator modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    GPA_OSC_LP = 4'b0000,
    GPA_OSC_XT = 4'b0001,
    GPA_OSC_HS = 4'b0010,
    GPA_OSC_HSPLL = 4'b0011,
    GPA_OSC_RC = 4'b0100,
    GPA_OSC_RC_IO = 4'b0101,
    GPA_OSC_EXT_CLK = 4'b0110,
    GPA_OSC_EXT_CLK_IO = 4'b0111,
    GPA_OSC_INT_TWO_IO = 4'b1000,
    GPA_OSC_INT_CLK_OUT = 4'b1001
  } gpa_osc_mode_t;

  localparam logic [3:0] GPA_RST_OSC = 4'b1000;

endpackage : gpa_pkg

// >>> src/gpa_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter per bit.
// Assumes: Pins are asynchronous to clk_sys_i.
// Notes:   Output follows only when stages two and three agree.
`timescale 1ns/10ps
module gpa_pin_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Raw and filtered levels
  input wire logic [7:0] pin_raw_i,
  output logic [7:0] pin_sync_o
);

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic out_ff;
      // First stage is read only by the second, to contain metastability
      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
        end else begin
          s1_ff <= pin_raw_i[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end
      // Accept a change once two settled stages agree
      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          out_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
          out_ff <= s3_ff;
        end
      end
      assign pin_sync_o[gi] = out_ff;
    end
  endgenerate

endmodule : gpa_pin_sync

// >>> src/gpa_port.sv
// Purpose: 8-bit general purpose port with direction, latch and pin read paths.
// Assumes: clk_sys_i at 25 MHz is also the oscillator clock seen by the port.
// Notes:   Registers sit on Avalon-MM; each access costs one wait cycle.
//
// Notes on behaviour
// [R1] Eight pins, each with its own direction bit.
// [R2] Direction bit 1 turns the pin driver off; the pin is an input.
// [R3] Direction bit 0 drives the pin from its latch bit.
// [R4] Pin register reads pin levels; writing it updates the latch.
// [R5] Latch register reads back the latched value, not the pins.
// [R6] Top two pins read zero in all three registers when owned by oscillator.
// [R7] Pin six is port I/O only in RC-io, internal-two-io and ext-clock-io.
// [R8] Pin seven port paths are off in external oscillator modes.
// [R9] Pin six outputs cycle clock, oscillator over four, in listed modes.
// [R10] Four-bit analog select field decides analog or digital for low pins.
// [R11] After reset pins 0-3 and 5 are analog reading zero; pin 4 digital.
// [R12] Analog pins have their digital input read path disabled.
// [R13] Analog selection leaves the output driver under direction control.
// [R14] Software keeps direction bits at 1 for pins used as analog.
// [R15] Pin four is Schmitt input, open drain low only; others push-pull.
// [R16] Pin four feeds the timer clock input whatever its direction.
// [R17] An enabled shared peripheral takes the pin away from port use.
// [R18] Pin inputs are synchronised before the read path.
// [R19] Latch writes land while input; they show once direction clears.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module gpa_port
  import gpa_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port pins
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  // Shared peripheral side
  output logic timer_ext_clock_in_o,
  output logic [7:0] analog_en_o,
  output logic [1:0] reference_select_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] latch_ff;
  logic [7:0] dir_ff;
  logic [3:0] asel_ff;
  logic [1:0] rsel_ff;
  logic [3:0] osc_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic half_ff;
  logic cyc_clk_ff;
  logic [7:0] pin_sync;
  logic [7:0] avail;
  logic [7:0] analog;
  logic [7:0] pin_rd_val;
  logic [31:0] nxt_rdata;
  logic cyc_clk_drive;
  logic pin6_io;
  logic pin7_io;
  logic tick;
  logic req;
  logic wr_go;
  logic rd_start;
  logic wr_lane0;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  gpa_pin_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_raw_i(pin_in_i),
    .pin_sync_o(pin_sync) // R18
  );

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access gives the read mux a full cycle to settle
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_ff;
  assign wr_go = avs_write_i & ack_ff;
  assign rd_start = avs_read_i & ~ack_ff;
  assign wr_lane0 = wr_go & avs_byteenable_i[0];

  // Acknowledge follows the first cycle of each request
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator mode decode
  // ----------------------------------------------------------------
  // Unknown codes fall back to a crystal mode: both top pins stay with the oscillator
  always_comb begin
    pin6_io = 1'b0;
    pin7_io = 1'b0;
    cyc_clk_drive = 1'b0;
    unique case (gpa_osc_mode_t'(osc_ff))
      GPA_OSC_RC_IO, GPA_OSC_EXT_CLK_IO: begin
        pin6_io = 1'b1; // R7
      end
      GPA_OSC_INT_TWO_IO: begin
        pin6_io = 1'b1; // R7
        pin7_io = 1'b1; // R8
      end
      GPA_OSC_INT_CLK_OUT: begin
        pin7_io = 1'b1; // R8
      end
      GPA_OSC_RC, GPA_OSC_EXT_CLK: begin
        cyc_clk_drive = 1'b0; // R9
      end
      GPA_OSC_LP, GPA_OSC_XT, GPA_OSC_HS, GPA_OSC_HSPLL: begin
        cyc_clk_drive = 1'b1; // R9
      end
      default: begin
        cyc_clk_drive = 1'b1;
      end
    endcase
  end

  // Port ownership: oscillator duties win over port use
  always_comb begin
    avail = 8'hFF; // R1
    avail[GPA_BIT_CYC_OUT] = pin6_io; // R17
    avail[GPA_BIT_MAIN_IN] = pin7_io; // R17
  end

  // ----------------------------------------------------------------
  // Analog select decode
  // ----------------------------------------------------------------
  // Channel n is analog while the select code is at most TOP minus n
  always_comb begin
    analog = 8'h00;
    for (int k = 0; k < 4; k++) begin
      analog[k] = (asel_ff <= (GPA_ASEL_TOP - 4'(k))); // R10
    end
    analog[5] = (asel_ff <= (GPA_ASEL_TOP - GPA_PIN5_CHAN)); // R10
    analog = analog & GPA_ANALOG_PINS;
  end

  assign analog_en_o = analog;
  assign reference_select_o = rsel_ff;

  // ----------------------------------------------------------------
  // Cycle clock divider
  // ----------------------------------------------------------------
  // Half-rate enable, then a toggle on it: one quarter of clk_sys_i
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
    end
  end
  assign tick = half_ff;

  // Toggle the cycle clock on every enable pulse
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_clk_ff <= 1'b0;
    end else if (tick) begin
      cyc_clk_ff <= ~cyc_clk_ff; // R9
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Direction and oscillator ownership gate the drivers; analog selection does not
  always_comb begin
    pin_out_o = latch_ff; // R3
    pin_oe_o = ~dir_ff & avail; // R2 R13
    // Open drain: only ever pulls low
    pin_out_o[GPA_BIT_TMR] = 1'b0; // R15
    pin_oe_o[GPA_BIT_TMR] = ~dir_ff[GPA_BIT_TMR] & ~latch_ff[GPA_BIT_TMR]; // R15
    if (!pin6_io) begin
      pin_out_o[GPA_BIT_CYC_OUT] = cyc_clk_ff; // R9
      pin_oe_o[GPA_BIT_CYC_OUT] = cyc_clk_drive; // R9
    end
    if (!pin7_io) begin
      pin_out_o[GPA_BIT_MAIN_IN] = 1'b0; // R8
      pin_oe_o[GPA_BIT_MAIN_IN] = 1'b0; // R8
    end
  end

  // Timer clock sees the pin regardless of direction
  assign timer_ext_clock_in_o = pin_sync[GPA_BIT_TMR]; // R16

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Pin and latch addresses both land in the latch, even for input pins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_ff <= GPA_RST_LATCH;
    end else if (wr_lane0 && (avs_address_i == GPA_OFS_PIN_LEVEL ||
                              avs_address_i == GPA_OFS_OUT_LATCH)) begin
      latch_ff <= avs_writedata_i[7:0]; // R4 R19
    end
  end

  // Direction register, all inputs after reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_ff <= GPA_RST_DIR;
    end else if (wr_lane0 && avs_address_i == GPA_OFS_DIRECTION) begin
      dir_ff <= avs_writedata_i[7:0]; // R1
    end
  end

  // Converter configuration; reset leaves every analog pin analog
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      asel_ff <= GPA_RST_ASEL; // R11
      rsel_ff <= GPA_RST_RSEL;
    end else if (wr_lane0 && avs_address_i == GPA_OFS_CONV_CFG) begin
      asel_ff <= avs_writedata_i[GPA_ASEL_LSB +: 4]; // R10
      rsel_ff <= avs_writedata_i[GPA_RSEL_LSB +: 2];
    end
  end

  // Oscillator mode; normally set once at start-up
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_ff <= GPA_RST_OSC;
    end else if (wr_lane0 && avs_address_i == GPA_OFS_OSC_CFG) begin
      osc_ff <= avs_writedata_i[GPA_OSC_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Analog and oscillator-owned pins read as zero
  assign pin_rd_val = pin_sync & ~analog & avail; // R4 R6 R12

  // Read data captured in the first request cycle, held for the answer
  always_comb begin
    nxt_rdata = GPA_RD_UNMAPPED;
    unique case (avs_address_i)
      GPA_OFS_PIN_LEVEL: nxt_rdata[7:0] = pin_rd_val; // R4
      GPA_OFS_OUT_LATCH: nxt_rdata[7:0] = latch_ff & avail; // R5 R6
      GPA_OFS_DIRECTION: nxt_rdata[7:0] = dir_ff & avail; // R6
      GPA_OFS_CONV_CFG: begin
        nxt_rdata[GPA_ASEL_LSB +: 4] = asel_ff;
        nxt_rdata[GPA_RSEL_LSB +: 2] = rsel_ff;
      end
      GPA_OFS_OSC_CFG: nxt_rdata[GPA_OSC_LSB +: 4] = osc_ff;
      default: nxt_rdata = GPA_RD_UNMAPPED;
    endcase
  end

  // Load on the first cycle only, so data stand stable at completion
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= GPA_RD_UNMAPPED;
    end else if (rd_start) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign avs_readdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_rd_first(logic [4:0] ofs);
    avs_read_i && !ack_ff && avs_address_i == ofs;
  endsequence

  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence

  // Input direction never drives any pin except pin six
  dir_hiz_a: assert property ((pin_oe_o & dir_ff & ~(8'h01 << GPA_BIT_CYC_OUT)) == 8'h00) // R2
    else $error("driver enabled on an input pin");

  // Output pin carries the latch value
  drive_latch_a: assert property (!dir_ff[0] |-> pin_oe_o[0] && pin_out_o[0] == latch_ff[0]) // R3
    else $error("output pin does not show latch");

  // Write to pin address lands in latch, not in direction
  pin_write_a: assert property (
    wr_lane0 && avs_address_i == GPA_OFS_PIN_LEVEL |=>
      latch_ff == $past(avs_writedata_i[7:0]) && $stable(dir_ff)) // R4 R19
    else $error("pin register write missed the latch");

  // Pin read completes one cycle later with the sampled level
  pin_read_a: assert property (
    s_rd_first(GPA_OFS_PIN_LEVEL) |=> s_rd_done ##0
      avs_readdata_o[7:0] == $past(pin_rd_val)) // R4 R12
    else $error("pin read data wrong or late");

  // Latch read returns latched value
  latch_read_a: assert property (
    s_rd_first(GPA_OFS_OUT_LATCH) |=> s_rd_done ##0
      avs_readdata_o[7:0] == $past(latch_ff & avail)) // R5
    else $error("latch read data wrong");

  // Oscillator-owned top pin reads zero
  osc_zero_a: assert property (
    s_rd_first(GPA_OFS_DIRECTION) ##0 !pin7_io |=>
      avs_readdata_o[GPA_BIT_MAIN_IN] == 1'b0) // R6
    else $error("oscillator pin direction not zero");

  // Open drain pin never drives high
  od_low_a: assert property (pin_oe_o[GPA_BIT_TMR] |-> !pin_out_o[GPA_BIT_TMR] &&
                              !latch_ff[GPA_BIT_TMR]) // R15
    else $error("open drain pin driven high");

  // Cycle clock holds two cycles then flips
  clk_quarter_a: assert property (
    $rose(cyc_clk_ff) |-> cyc_clk_ff [*2] ##1 !cyc_clk_ff [*2] ##1 cyc_clk_ff) // R9
    else $error("cycle clock not a quarter rate");

  // Analog pin reads zero whatever the pin level
  analog_read_a: assert property (analog[0] |-> pin_rd_val[0] == 1'b0) // R12
    else $error("analog pin shows digital level");

  // Analog code 0 selects all five analog channels
  analog_dec_a: assert property (asel_ff == GPA_RST_ASEL |-> analog == GPA_ANALOG_PINS) // R10 R11
    else $error("analog decode wrong at code zero");

  // Every request waits exactly once
  one_wait_a: assert property (req && !ack_ff |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus wait not one cycle");

endmodule : gpa_port

// >>> verification/gpa_board.sv
// Purpose: Board circuitry on the port pins: stimulus drivers, pull-up, floating lines.
// Assumes: The bench never drives a pin while the block drives it.
// Notes:   A floating line toggles each cycle, so a stale level is never read as valid.
`timescale 1ns/10ps
module gpa_board (
  // Clock
  input wire logic clk_sys_i,
  // Block side
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  // Bench stimulus
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  // Resolved pin levels
  output logic [7:0] pin_o
);
  logic float_ff = 1'b0;

  // --------
  // Floating level
  // --------
  // Changes every cycle so an undriven line holds no old value
  always @(posedge clk_sys_i) begin
    float_ff <= ~float_ff;
  end

  // Wire level: the block, then the bench, then pull-up or float
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_o[k] = pin_oe_i[k] ? pin_out_i[k] : ext_en_i[k] ? ext_val_i[k] :
                 (k == 4) ? 1'b1 : float_ff;
    end
  end
endmodule : gpa_board

// >>> verification/tb_eight_bit_gpio_port_with_analog_share.sv
// Purpose: Self-checking bench for the 8-bit port with analog share.
// Assumes: One wait cycle per bus access; pin reads settle four edges after a change.
// Notes:   A monitor checks each completed read against a queue of expected words.
`timescale 1ns/10ps
module tb_eight_bit_gpio_port_with_analog_share
  import gpa_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_req;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] an_en;
  logic [1:0] ref_sel;
  logic tmr_clk;
  logic [7:0] ext_val = 8'hFF;
  logic [7:0] ext_en = 8'hFF;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  int seed = 54504;

  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;

  gpa_port dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .avs_address_i(addr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdata),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req),
    .pin_in_i(pin_in),
    .pin_out_o(pin_out),
    .pin_oe_o(pin_oe),
    .timer_ext_clock_in_o(tmr_clk),
    .analog_en_o(an_en),
    .reference_select_o(ref_sel)
  );

  gpa_board board (
    .clk_sys_i(clk_sys_i),
    .pin_out_i(pin_out),
    .pin_oe_i(pin_oe),
    .ext_val_i(ext_val),
    .ext_en_i(ext_en),
    .pin_o(pin_in)
  );

  // --------
  // Reporting and compares
  // --------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h0, got}, {24'h0, exp});
  endtask : chk_pin

  // --------
  // Avalon master: request held until waitrequest is seen low
  // --------
  task automatic bus(input logic is_rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    rd <= is_rd;
    wr <= ~is_rd;
    addr <= a;
    wdata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_i);
      if (wait_req === 1'b0) break;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
  endtask : bus

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask : bus_rd

  // Read data is taken only at the completing edge
  always @(posedge clk_sys_i) begin
    if (rd && wait_req === 1'b0 && exp_q.size() > 0) begin
      chk_word(rdata, exp_q.pop_front());
    end
  end

  // --------
  // Main sequence
  // --------
  initial begin
    logic [7:0] lat;
    logic [7:0] an_x;
    logic [7:0] msk;
    logic [7:0] v;
    logic b6;
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    // Reset state; board drives every pin high, analog pins stay input
    chk_pin(pin_oe, 8'h00);
    chk_pin(an_en, GPA_ANALOG_PINS);
    chk_pin({7'h0, tmr_clk}, 8'h01);
    bus_rd(GPA_OFS_DIRECTION, 32'hFF);
    bus_rd(GPA_OFS_OUT_LATCH, 32'h00);
    bus_rd(GPA_OFS_CONV_CFG, 32'h00);
    bus_rd(GPA_OFS_OSC_CFG, 32'h08);
    bus_rd(GPA_OFS_PIN_LEVEL, 32'hD0);
    bus_rd(5'h14, 32'h0);
    // Latch written through the pin register while all pins are inputs
    lat = 8'($random(seed));
    bus_wr(GPA_OFS_PIN_LEVEL, {24'h0, lat});
    bus_rd(GPA_OFS_OUT_LATCH, {24'h0, lat});
    chk_pin(pin_oe, 8'h00);
    ext_en <= 8'h00;
    bus_wr(GPA_OFS_DIRECTION, 32'h0);
    @(posedge clk_sys_i);
    chk_pin(pin_oe, {3'b111, ~lat[4], 4'hF});
    chk_pin(pin_out & pin_oe, {lat[7:5], 1'b0, lat[3:0]});
    repeat (6) @(posedge clk_sys_i);
    // Every analog select code, pins driven from the latch
    for (int s = 0; s < 16; s++) begin
      an_x = {2'b00, s <= 10, 1'b0, s <= 11, s <= 12, s <= 13, s <= 14};
      bus_wr(GPA_OFS_CONV_CFG, 32'(s));
      bus_rd(GPA_OFS_PIN_LEVEL, {24'h0, lat & ~an_x});
      chk_pin(an_en, an_x);
    end
    bus_wr(GPA_OFS_CONV_CFG, 32'hFFFF_FFFF);
    bus_rd(GPA_OFS_CONV_CFG, 32'h3F);
    chk_pin({6'h0, ref_sel}, 8'h03);
    // Timer input follows pin four while it is an output
    chk_pin({7'h0, tmr_clk}, {7'h0, lat[4]});
    lat = lat ^ 8'h10;
    bus_wr(GPA_OFS_OUT_LATCH, {24'h0, lat});
    repeat (6) @(posedge clk_sys_i);
    chk_pin({7'h0, tmr_clk}, {7'h0, lat[4]});
    // Write without the low byte lane is ignored
    @(posedge clk_sys_i);
    be <= 4'hE;
    bus_wr(GPA_OFS_OUT_LATCH, {24'h0, ~lat});
    be <= 4'hF;
    bus_rd(GPA_OFS_OUT_LATCH, {24'h0, lat});
    // Every oscillator mode and one unused code: ownership of the top two pins
    for (int m = 0; m < 11; m++) begin
      msk = {m == 8 || m == 9, m == 5 || m == 7 || m == 8, 6'h3F};
      bus_wr(GPA_OFS_OSC_CFG, 32'(m));
      bus_wr(GPA_OFS_DIRECTION, 32'hC0);
      bus_rd(GPA_OFS_DIRECTION, {24'h0, 8'hC0 & msk});
      bus_rd(GPA_OFS_OUT_LATCH, {24'h0, lat & msk});
      bus_wr(GPA_OFS_DIRECTION, 32'h0);
      repeat (6) @(posedge clk_sys_i);
      chk_pin(pin_oe & 8'hC0, {msk[7], msk[6] | (m < 4) | (m > 9), 6'h0});
      bus_rd(GPA_OFS_PIN_LEVEL, {24'h0, lat & msk});
    end
    // Cycle clock at a quarter of the clock rate
    bus_wr(GPA_OFS_OSC_CFG, 32'h2);
    repeat (4) begin
      @(posedge clk_sys_i);
      b6 = pin_out[6];
      repeat (2) @(posedge clk_sys_i);
      chk_pin({7'h0, pin_out[6]}, {7'h0, ~b6});
    end
    // Input change is not seen before the synchroniser has passed it
    bus_wr(GPA_OFS_OSC_CFG, 32'h8);
    bus_wr(GPA_OFS_DIRECTION, 32'hFF);
    v = 8'($random(seed));
    ext_val <= v;
    ext_en <= 8'hFF;
    repeat (6) @(posedge clk_sys_i);
    ext_val <= ~v;
    bus_rd(GPA_OFS_PIN_LEVEL, {24'h0, v});
    repeat (6) @(posedge clk_sys_i);
    bus_rd(GPA_OFS_PIN_LEVEL, {24'h0, ~v});
    repeat (2) @(posedge clk_sys_i);
    complete_run();
  end
endmodule : tb_eight_bit_gpio_port_with_analog_share
